// [timer_pwm_channels.sv]
// Two-channel 16-bit modulo timer with unbuffered and linked buffered PWM,
// register access over an AHB-Lite slave. Assumes one clock, one master, and
// that the external clock pin is already synchronous to i_mclk.
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps

module timer_pwm_channels
  import timer_pwm_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // AHB-Lite slave.
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // External timer clock pin.
  input  wire logic        i_ext_clk,
  // Channel pins.
  output logic             o_pwm_out_pin,
  output logic             o_pwm_out_pin_oe,
  output logic             o_second_channel_pin,
  output logic             o_second_channel_pin_oe,
  // Interrupt request to the system.
  output logic             o_timer_irq
);

  // Bus address phase capture.
  logic        dp_valid;
  logic        dp_write;
  logic [7:0]  dp_addr;
  wire  logic  addr_take = i_hsel & i_hready & i_htrans[1];

  // Registers.
  logic [7:0]  control;
  logic [15:0] counter;
  logic [15:0] modulo_value;
  logic        modulo_gate;
  logic [7:0]  ch_ctrl [2];
  logic [15:0] ch_cmp  [2];
  logic [1:0]  ch_pin;
  logic [3:0]  sys;
  logic        active_set;
  logic        next_set;
  logic [5:0]  prescale;
  logic        ext_prev;
  logic        wrap_armed;
  logic [1:0]  ch_armed;

  // Register select strobes; writes decode in the data phase, rd_take in the address phase.
  wire logic wr       = dp_valid & dp_write;
  wire logic rd_take  = addr_take & ~i_hwrite;
  wire logic wr_ctl   = wr & (dp_addr == OFS_CONTROL);
  wire logic wr_mod   = wr & (dp_addr == OFS_MODULO);
  wire logic wr_c0c   = wr & (dp_addr == OFS_CH0_CTRL);
  wire logic wr_c0v   = wr & (dp_addr == OFS_CH0_CMP);
  wire logic wr_c1c   = wr & (dp_addr == OFS_CH1_CTRL);
  wire logic wr_c1v   = wr & (dp_addr == OFS_CH1_CMP);
  wire logic wr_sys   = wr & (dp_addr == OFS_SYSTEM);
  // A word write models the high then low byte; write data bit 31 marks a high-only write that sets the gate.
  wire logic wr_mod_hi_only = wr_mod & (i_hwdata[31]);

  // Halting conditions: software halt, stop mode, break state.
  // Wait mode is left out on purpose, since the timer keeps counting in wait.
  // stop freezes
  wire logic halted   = control[B_HALT] | sys[B_SYS_STOP] | sys[B_SYS_BREAK];
  // In break, flags only clear when the break-clear enable is set.
  // clear guard
  wire logic clr_ok   = ~sys[B_SYS_BREAK] | sys[B_SYS_BREAK_CLEAR_ENABLE];

  // Timer tick selection from the prescaler or external pin.
  // A divided tick is the one cycle in which the selected prescaler bit first reads one.
  // The external pin is sampled once per clock, so it must run at no more than half that rate.
  // divider select
  wire logic [2:0] div_sel = control[B_DIV_HI:0];
  wire logic [6:0] pre_next = {1'b0, prescale} + 7'h01;
  wire logic ext_rise = i_ext_clk & ~ext_prev;
  logic tick_sel;
  always_comb
  begin
    tick_sel = 1'b0;
    case (div_sel)
      3'h0:         tick_sel = 1'b1;
      DIV_EXTERNAL: tick_sel = ext_rise;
      default:      tick_sel = (prescale & ((6'h01 << (div_sel - 3'h1)) - 6'h01)) == 6'h00 &&
                               prescale[div_sel - 3'h1];
    endcase
  end
  wire logic tick     = tick_sel & ~halted;

  wire logic at_mod   = (counter == modulo_value);
  wire logic wrap     = tick & at_mod;

  // Channel mode decode; buffered bit wins over unbuffered.
  // buffered priority
  wire logic linked   = ch_ctrl[0][B_BUF_SEL];
  wire logic oc0      = linked | ch_ctrl[0][B_UNBUF_SEL];
  wire logic oc1      = ~linked & ch_ctrl[1][B_UNBUF_SEL];
  wire logic [15:0] cmp0 = linked ? ch_cmp[active_set] : ch_cmp[0];
  wire logic match0   = tick & oc0 & (counter == cmp0);
  wire logic match1   = tick & oc1 & (counter == ch_cmp[1]);

  // Read mux; the counter-reset bit always reads zero.
  // Read data is captured at the address edge, so no wait state is ever needed.
  // reads zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (i_haddr)
      OFS_CONTROL:  rd_mux = {24'h000000, control & ~(8'h01 << B_CNT_RESET)};
      OFS_COUNTER:  rd_mux = {16'h0000, counter};
      OFS_MODULO:   rd_mux = {16'h0000, modulo_value};
      OFS_CH0_CTRL: rd_mux = {24'h000000, ch_ctrl[0]};
      OFS_CH0_CMP:  rd_mux = {16'h0000, ch_cmp[0]};
      OFS_CH1_CTRL: rd_mux = {24'h000000, ch_ctrl[1]};
      OFS_CH1_CMP:  rd_mux = {16'h0000, ch_cmp[1]};
      OFS_SYSTEM:   rd_mux = {28'h0000000, sys};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus phase tracking; every transfer answers OKAY with no wait states.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dp_valid    <= 1'b0;
      dp_write    <= 1'b0;
      dp_addr     <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= HRESP_OKAY;
    end
    else
    begin
      dp_valid <= addr_take;
      dp_write <= i_hwrite;
      dp_addr  <= i_haddr;
      if (rd_take)
        o_hrdata <= rd_mux;
    end
  end

  // Flag arming: a read that sees the flag set arms the later zero-write clear.
  // An event between the read and the zero write disarms it, so no event is lost.
  // read arms clear
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wrap_armed <= 1'b0;
      ch_armed   <= 2'h0;
    end
    else
    begin
      if (rd_take && i_haddr == OFS_CONTROL)
        wrap_armed <= control[B_WRAP_FLAG];
      else if (wrap)
        wrap_armed <= 1'b0;
      if (rd_take && i_haddr == OFS_CH0_CTRL)
        ch_armed[0] <= ch_ctrl[0][B_CH_FLAG];
      else if (match0)
        ch_armed[0] <= 1'b0;
      if (rd_take && i_haddr == OFS_CH1_CTRL)
        ch_armed[1] <= ch_ctrl[1][B_CH_FLAG];
      else if (match1)
        ch_armed[1] <= 1'b0;
    end
  end

  // Timer control, modulo, counter and prescaler.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      control      <= CONTROL_RESET;
      modulo_value <= MODULO_RESET;
      modulo_gate  <= 1'b0;
      counter      <= ZERO16;
      prescale     <= 6'h00;
      ext_prev     <= 1'b0;
      sys          <= 4'h0;
    end
    else
    begin
      ext_prev <= i_ext_clk;
      if (wr_sys)
        sys <= i_hwdata[3:0];
      if (wr_ctl)
        control[6:0] <= i_hwdata[6:0];
      // wrap flag set, wins over clear
      if (wrap && !modulo_gate)
        control[B_WRAP_FLAG] <= 1'b1;
      else if (wr_ctl && !i_hwdata[B_WRAP_FLAG] && wrap_armed && clr_ok)
        control[B_WRAP_FLAG] <= 1'b0;
      // high write gates flag until low written
      if (wr_mod)
      begin
        modulo_value <= i_hwdata[15:0];
        modulo_gate  <= wr_mod_hi_only;
      end
      if (wr_ctl && i_hwdata[B_CNT_RESET])
      begin
        counter  <= ZERO16;
        prescale <= 6'h00;
        control[B_CNT_RESET] <= 1'b0;
      end
      else if (!halted)
      begin
        prescale <= pre_next[5:0];
        if (tick)
          counter <= at_mod ? ZERO16 : counter + ONE16;
      end
    end
  end

  // Channel registers, buffer selection, flags and pins.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ch_ctrl[0] <= 8'h00;
      ch_ctrl[1] <= 8'h00;
      ch_cmp[0]  <= ZERO16;
      ch_cmp[1]  <= ZERO16;
      ch_pin     <= 2'b00;
      active_set <= 1'b0;
      next_set   <= 1'b0;
    end
    else
    begin
      if (wr_c0c)
        ch_ctrl[0][6:0] <= i_hwdata[6:0];
      if (wr_c1c && !linked)
        // Channel 1 has no link bit, so that position always stores and reads zero.
        ch_ctrl[1][6:0] <= {i_hwdata[6], 1'b0, i_hwdata[4:0]};
      if (wr_c0v)
        ch_cmp[0] <= i_hwdata[15:0];
      if (wr_c1v)
        ch_cmp[1] <= i_hwdata[15:0];
      // Outside linked mode the choice resets, so linking always starts on channel 0.
      // last written set takes over at wrap
      if (wr_c0v || !linked)
        next_set <= 1'b0;
      else if (wr_c1v)
        next_set <= 1'b1;
      if (!linked)
        active_set <= 1'b0;
      else if (wrap)
        active_set <= next_set;
      if (match0)
        ch_ctrl[0][B_CH_FLAG] <= 1'b1;
      else if (wr_c0c && !i_hwdata[B_CH_FLAG] && ch_armed[0] && clr_ok)
        ch_ctrl[0][B_CH_FLAG] <= 1'b0;
      if (match1)
        ch_ctrl[1][B_CH_FLAG] <= 1'b1;
      else if (wr_c1c && !i_hwdata[B_CH_FLAG] && ch_armed[1] && clr_ok)
        ch_ctrl[1][B_CH_FLAG] <= 1'b0;
      ch_pin[0] <= pin_next(ch_pin[0], ch_ctrl[0], wrap & oc0, match0);
      ch_pin[1] <= pin_next(ch_pin[1], ch_ctrl[1], wrap & oc1, match1);
    end
  end

  // Pin update: wrap toggle then compare action; compare applies last.
  function automatic logic pin_next(input logic cur, input logic [7:0] ctl,
                                    input logic wrp, input logic mat);
    logic v;
    compare_action_t act;
    v   = cur;
    act = compare_action_t'({ctl[B_ELS_B], ctl[B_ELS_A]});
    // Forcing the level beats both events, so the pin never glitches at wrap.
    // full duty
    if (ctl[B_FULL_DUTY] && ctl[B_TOGGLE_WRAP])
      v = ~act[0];
    else
    begin
      if (wrp && ctl[B_TOGGLE_WRAP])
        v = ~v;
      if (mat)
      begin
        case (act)
          ACT_TOGGLE: v = ~v;
          ACT_CLEAR:  v = 1'b0;
          ACT_SET:    v = 1'b1;
          default:    v = v;
        endcase
      end
    end
    pin_next = v;
  endfunction : pin_next

  // Output pins and interrupt, all registered.
  // enabled requests wake
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pwm_out_pin           <= 1'b0;
      o_pwm_out_pin_oe        <= 1'b0;
      o_second_channel_pin    <= 1'b0;
      o_second_channel_pin_oe <= 1'b0;
      o_timer_irq             <= 1'b0;
    end
    else
    begin
      o_pwm_out_pin           <= ch_pin[0];
      o_pwm_out_pin_oe        <= oc0 & (ch_ctrl[0][B_ELS_B] | ch_ctrl[0][B_ELS_A]);
      o_second_channel_pin    <= ch_pin[1];
      // Releasing the pin while linked leaves it to the port as plain I/O.
      // second pin free while linked
      o_second_channel_pin_oe <= oc1 & (ch_ctrl[1][B_ELS_B] | ch_ctrl[1][B_ELS_A]);
      o_timer_irq <= (control[B_WRAP_FLAG] & control[B_WRAP_IE]) |
                     (ch_ctrl[0][B_CH_FLAG] & ch_ctrl[0][B_CH_IE]) |
                     (ch_ctrl[1][B_CH_FLAG] & ch_ctrl[1][B_CH_IE]);
    end
  end

endmodule : timer_pwm_channels

// [timer_pwm_pkg.sv]
// Package of register offsets, field positions, reset values and codes for the
// two-channel PWM timer. Used by the AHB-Lite register slave in timer_pwm_channels.
package timer_pwm_pkg;

  // Register byte offsets, one aligned 32-bit word each.
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_COUNTER  = 8'h04;
  localparam logic [7:0] OFS_MODULO   = 8'h08;
  localparam logic [7:0] OFS_CH0_CTRL = 8'h0C;
  localparam logic [7:0] OFS_CH0_CMP  = 8'h10;
  localparam logic [7:0] OFS_CH1_CTRL = 8'h14;
  localparam logic [7:0] OFS_CH1_CMP  = 8'h18;
  localparam logic [7:0] OFS_SYSTEM   = 8'h1C;

  // Timer control/status fields.
  localparam int B_WRAP_FLAG  = 7;
  localparam int B_WRAP_IE    = 6;
  localparam int B_HALT       = 5;
  localparam int B_CNT_RESET  = 4;
  localparam int B_DIV_HI     = 2;

  // Channel control/status fields.
  localparam int B_CH_FLAG    = 7;
  localparam int B_CH_IE      = 6;
  localparam int B_BUF_SEL    = 5;
  localparam int B_UNBUF_SEL  = 4;
  localparam int B_ELS_B      = 3;
  localparam int B_ELS_A      = 2;
  localparam int B_TOGGLE_WRAP = 1;
  localparam int B_FULL_DUTY  = 0;

  // System register fields: wait, stop, break, break-clear enable.
  localparam int B_SYS_WAIT   = 0;
  localparam int B_SYS_STOP   = 1;
  localparam int B_SYS_BREAK  = 2;
  localparam int B_SYS_BREAK_CLEAR_ENABLE   = 3;

  // Reset values.
  localparam logic [7:0]  CONTROL_RESET = 8'h20;
  localparam logic [15:0] MODULO_RESET  = 16'hFFFF;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [15:0] ONE16         = 16'h0001;

  // Prescaler code that selects the external clock pin.
  localparam logic [2:0] DIV_EXTERNAL   = 3'h7;

  // AHB-Lite transfer and response codes.
  localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0] HTRANS_SEQ     = 2'h3;
  localparam logic       HRESP_OKAY     = 1'h0;

  // Channel output-compare action.
  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } compare_action_t;

endpackage : timer_pwm_pkg

// [timer_pwm_properties.sv]
// Concurrent checks on the timer's bus and pin ports.
// Assumes one slave whose hready input follows its own hreadyout.
`timescale 1ns/10ps
module timer_pwm_properties
  import timer_pwm_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  input wire logic        i_hsel,
  input wire logic [7:0]  i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [2:0]  i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  // Pins and request.
  input wire logic        i_ext_clk,
  input wire logic        o_pwm_out_pin,
  input wire logic        o_pwm_out_pin_oe,
  input wire logic        o_second_channel_pin,
  input wire logic        o_second_channel_pin_oe,
  input wire logic        o_timer_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic       dp_v;
  logic       dp_wr;
  logic [7:0] dp_a;
  wire        take = i_hsel & i_hready & i_htrans[1];
  wire        ch0_wr = dp_v & dp_wr & (dp_a == OFS_CH0_CTRL);
  // Data phase tracking, since write data trails its address by a cycle.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dp_v  <= 1'b0;
      dp_wr <= 1'b0;
      dp_a  <= 8'h00;
    end
    else
    begin
      dp_v  <= take;
      dp_wr <= i_hwrite;
      dp_a  <= i_haddr;
    end
  end
  hready_a: assert property (o_hreadyout) else $error("hreadyout low");
  okay_a: assert property (o_hresp == HRESP_OKAY) else $error("response not okay");
  unmapped_a: assert property (take && !i_hwrite && i_haddr > 8'h1C |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  rst_bit_a: assert property (take && !i_hwrite && i_haddr == OFS_CONTROL
    |=> !o_hrdata[B_CNT_RESET]) else $error("counter reset bit reads one");
  irq_a: assert property (dp_v && !dp_wr && dp_a == OFS_CONTROL && o_hrdata[7]
    && o_hrdata[6] |-> ##[0:1] o_timer_irq) else $error("enabled wrap flag gave no request");
  link_oe_a: assert property (ch0_wr && i_hwdata[B_BUF_SEL]
    |-> ##[1:3] !o_second_channel_pin_oe) else $error("second pin driven while linked");
  pin_oe_a: assert property (ch0_wr && (i_hwdata[5] | i_hwdata[4]) && i_hwdata[3:2] != 2'h0
    |-> ##[1:3] o_pwm_out_pin_oe) else $error("compare pin not driven");
  pin_off_a: assert property (ch0_wr && i_hwdata[3:2] == 2'h0
    |-> ##[1:3] !o_pwm_out_pin_oe) else $error("pin driven with no edge action");
endmodule : timer_pwm_properties

// [pwm_monitor.sv]
// Load on the PWM pin: measures period and high time between rising edges.
// Assumes the pin is synchronous to i_mclk.
`timescale 1ns/10ps
module pwm_monitor
(
  // Clock and observed pin.
  input  wire logic        i_mclk,
  input  wire logic        i_pin,
  // Last full period and high time, in clocks.
  output logic      [15:0] o_period,
  output logic      [15:0] o_high
);
  logic        prev = 1'b0;
  logic [15:0] run  = 16'h0000;
  logic [15:0] hi   = 16'h0000;
  // Figures are latched at each rise so a stuck pin leaves stale values.
  always @(posedge i_mclk)
  begin
    prev <= i_pin;
    if (i_pin && !prev)
    begin
      o_period <= run;
      o_high   <= hi;
      run      <= 16'h0001;
      hi       <= 16'h0001;
    end
    else
    begin
      run <= run + 16'h0001;
      hi  <= hi + {15'h0000, i_pin};
    end
  end
endmodule : pwm_monitor

// [tb_top.sv]
// Self-checking bench for the PWM timer, driven over its AHB-Lite slave.
// Assumes the external clock pin is synchronous, toggling every clock.
`timescale 1ns/10ps
module tb_top
  import timer_pwm_pkg::*;
;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        ext_clk = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  logic [31:0] a;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, pin, pin_oe, pin2, pin2_oe, irq;
  logic [15:0] per, hi;
  int          err_count = 0;
  int          checks = 0;
  int          k, n, m;
  always #20 mclk = ~mclk;
  // External timer clock rises every second system clock.
  always @(posedge mclk) ext_clk <= ~ext_clk;
  timer_pwm_channels u_dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .i_ext_clk(ext_clk), .o_pwm_out_pin(pin), .o_pwm_out_pin_oe(pin_oe),
    .o_second_channel_pin(pin2), .o_second_channel_pin_oe(pin2_oe), .o_timer_irq(irq));
  pwm_monitor u_mon (.i_mclk(mclk), .i_pin(pin), .o_period(per), .o_high(hi));
  task complete_run;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  // Waits for hready at a rising edge; a stuck slave ends the run.
  task hwait;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 99)
      begin
        err_count++;
        complete_run;
      end
      @(posedge mclk);
    end
  endtask : hwait
  // One single word transfer; read data lands in q.
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hwait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    q = hrdata;
  endtask : bus
  initial
  begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    bus(0, OFS_CONTROL, 0);
    chk("control reset", q, {24'h0, CONTROL_RESET});
    bus(0, OFS_MODULO, 0);
    chk("modulo reset", q, {16'h0, MODULO_RESET});
    bus(0, 8'h20, 0);
    chk("unmapped", q, 32'h0);
    bus(1, OFS_CH0_CTRL, 32'h10);
    bus(1, OFS_CH1_CTRL, 32'h1A);
    // Divider codes 0, 1 and the external pin, each with halt-first setup.
    for (k = 0; k < 3; k++)
    begin
      a = (k == 2) ? 32'(DIV_EXTERNAL) : 32'(k);
      m = (k == 0) ? 1 : 2;
      bus(1, OFS_CONTROL, 32'h30 | a);
      bus(1, OFS_MODULO, 32'hF);
      bus(1, OFS_CH0_CMP, 32'h8);
      bus(1, OFS_CH0_CTRL, 32'h1A);
      bus(1, OFS_CONTROL, a);
      repeat (110) @(posedge mclk);
      chk("period", per, 16 * m);
      chk("width", (hi >= 8 * m && hi <= 9 * m), 1);
      bus(0, OFS_CONTROL, 0);
      chk("control", q & 32'h3F, a);
    end
    // Flag write of one is ignored; read then zero clears.
    bus(1, OFS_CONTROL, 32'hE0);
    bus(0, OFS_CONTROL, 0);
    chk("flag set", q[7], 1);
    chk("request", irq, 1);
    bus(1, OFS_CONTROL, 32'hA0);
    bus(0, OFS_CONTROL, 0);
    chk("flag kept", q[7], 1);
    repeat (2) @(posedge mclk);
    chk("masked", irq, 0);
    bus(1, OFS_CONTROL, 32'h20);
    bus(0, OFS_CONTROL, 0);
    chk("flag clear", q[7], 0);
    // Channel flags: set by compares, request only when enabled, guarded in break.
    bus(0, OFS_CH0_CTRL, 0);
    chk("ch flag", q[7], 1);
    bus(1, OFS_CH0_CTRL, 32'hDA);
    bus(0, OFS_CH0_CTRL, 0);
    chk("ch request", irq, 1);
    bus(1, OFS_CH0_CTRL, 32'h1A);
    bus(0, OFS_CH0_CTRL, 0);
    chk("ch clear", q[7], 0);
    chk("ch masked", irq, 0);
    bus(0, OFS_CH1_CTRL, 0);
    chk("ch1 flag", q[7], 1);
    for (k = 0; k < 2; k++)
    begin
      bus(1, OFS_SYSTEM, k ? 32'hC : 32'h4);
      bus(1, OFS_CH1_CTRL, 32'h1A);
      bus(0, OFS_CH1_CTRL, 0);
      chk("break clear", q[7], (k == 0));
    end
    bus(1, OFS_SYSTEM, 0);
    // Wait keeps counting; stop and break freeze the counter until released.
    bus(1, OFS_CONTROL, 0);
    for (k = 0; k < 3; k++)
    begin
      bus(1, OFS_SYSTEM, 32'h1 << k);
      bus(0, OFS_COUNTER, 0);
      a = q;
      repeat (5) @(posedge mclk);
      bus(0, OFS_COUNTER, 0);
      chk("stopped", q == a, (k != 0));
      a = q;
      bus(1, OFS_SYSTEM, 0);
      repeat (5) @(posedge mclk);
      bus(0, OFS_COUNTER, 0);
      chk("resumed", q !== a, 1);
    end
    // No wrap toggle gives 0 percent, full duty with toggle gives 100.
    for (k = 0; k < 2; k++)
    begin
      bus(1, OFS_CH0_CTRL, k ? 32'h1B : 32'h18);
      repeat (40) @(posedge mclk);
      a = 0;
      q = 0;
      repeat (32)
      begin
        @(posedge mclk);
        a = a + pin;
        q = q + pin2;
      end
      chk("duty", a, k ? 32 : 0);
      chk("pin2 duty", q, 2);
    end
    chk("pin2 driven", pin2_oe, 1);
    // Both mode bits set: linking wins over the unbuffered bit.
    bus(1, OFS_CH0_CTRL, 32'h3A);
    repeat (3) @(posedge mclk);
    chk("pin2 freed", pin2_oe, 0);
    // Only the inactive set is written.
    bus(1, OFS_CH1_CMP, 32'h4);
    repeat (100) @(posedge mclk);
    chk("buffered width", (hi >= 4 && hi <= 5), 1);
    // A modulo write marked high-only holds off the wrap flag until a full write.
    bus(1, OFS_MODULO, 32'h8000_000F);
    bus(1, OFS_CONTROL, 32'h20);
    bus(0, OFS_CONTROL, 0);
    bus(1, OFS_CONTROL, 0);
    repeat (40) @(posedge mclk);
    bus(0, OFS_CONTROL, 0);
    chk("gated flag", q[7], 0);
    bus(1, OFS_MODULO, 32'hF);
    repeat (40) @(posedge mclk);
    bus(0, OFS_CONTROL, 0);
    chk("ungated flag", q[7], 1);
    complete_run;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    complete_run;
  end
endmodule : tb_top
bind timer_pwm_channels timer_pwm_properties u_prop (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_ext_clk(i_ext_clk),
  .o_pwm_out_pin(o_pwm_out_pin), .o_pwm_out_pin_oe(o_pwm_out_pin_oe),
  .o_second_channel_pin(o_second_channel_pin),
  .o_second_channel_pin_oe(o_second_channel_pin_oe), .o_timer_irq(o_timer_irq));
